// ---- cpu_core_pkg.sv ----
// Overview of operation
// RQ1: register or immediate arithmetic completes in one cycle
// RQ2: flags refreshed after each arithmetic/logic operation
// RQ3: 8-bit and 16-bit arithmetic plus logic, bits
// RQ4: 8x8 multiply, signed/unsigned/mixed, integer and fractional
// RQ5: every multiply takes exactly two clock cycles
// RQ6: fetch address counter is zero after reset
// RQ7: instructions are one or two 16-bit words
// RQ8: stack pointer resets to top of internal SRAM
// RQ9: stack pointer is two bytes, I/O read/write
// RQ10: push stores then decrements; pop increments
// RQ11: call and interrupt entry push return address
// RQ12: return address two bytes, three above 128KB
// RQ13: returns pop saved address into fetch counter
// RQ14: low-byte pointer write blocks interrupts four instructions; the code ends the block early at any other I/O write
// RQ15: software keeps stack pointer above SRAM base
// RQ16: flags never saved or restored by hardware
// RQ17: 32x8 register file, 8/16-bit read/write schemes
// RQ18: three register pairs form 16-bit pointers
// RQ19: internal SRAM begins at data address 0x2000
package cpu_core_pkg;
  localparam int RF_DEPTH = 32;
  localparam int FETCH_W = 22;
  localparam logic [FETCH_W-1:0] FETCH_RST = 22'h000000;
  localparam logic [15:0] SRAM_BASE = 16'h2000;
  localparam logic [15:0] SRAM_TOP_RST = 16'h3FFF;
  localparam int PROG_KB_RST = 128;
  localparam int RET_SPLIT_KB = 128;
  localparam logic [5:0] IO_STACK_LO = 6'h3D;
  localparam logic [5:0] IO_STACK_HI = 6'h3E;
  localparam logic [5:0] IO_FLAGS = 6'h3F;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [2:0] GUARD_INSTR = 3'h4;
  localparam logic [4:0] MUL_LO = 5'h00;
  localparam logic [4:0] MUL_HI = 5'h01;
  localparam logic [4:0] PTR_A_LO = 5'h1A;
  localparam logic [4:0] PTR_B_LO = 5'h1C;
  localparam logic [4:0] PTR_C_LO = 5'h1E;
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_ALU = 4'b0001, OP_ALU16 = 4'b0010,
    OP_MUL = 4'b0011, OP_PUSH = 4'b0100, OP_POP = 4'b0101,
    OP_CALL = 4'b0110, OP_INTR = 4'b0111,
    OP_RETURN_FROM_CALL = 4'b1000, OP_RETURN_FROM_INTERRUPT = 4'b1001
  } op_kind_t;

  typedef enum logic [3:0] {
    FN_ADD = 4'b0000, FN_ADC = 4'b0001, FN_SUB = 4'b0010,
    FN_SBC = 4'b0011, FN_AND = 4'b0100, FN_OR = 4'b0101,
    FN_XOR = 4'b0110, FN_COM = 4'b0111, FN_NEG = 4'b1000,
    FN_INC = 4'b1001, FN_DEC = 4'b1010, FN_LSR = 4'b1011,
    FN_ROR = 4'b1100, FN_ASR = 4'b1101, FN_SWAP = 4'b1110,
    FN_MOV = 4'b1111
  } alu_fn_t;

  // bit 2 selects fractional, low bits pick signedness
  typedef enum logic [2:0] {
    MK_UU = 3'b000, MK_SS = 3'b001, MK_SU = 3'b010,
    MK_FUU = 3'b100, MK_FSS = 3'b101, MK_FSU = 3'b110
  } mul_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_MUL = 3'b001, ST_CALL = 3'b010,
    ST_POP = 3'b011, ST_WAIT = 3'b100, ST_CAP = 3'b101
  } state_t;

  typedef struct packed {
    logic valid;
    op_kind_t kind;
    alu_fn_t fn;
    mul_kind_t mk;
    logic [4:0] dst;
    logic [4:0] src;
    logic [7:0] imm;
    logic use_imm;
    logic wb;
    logic two_word;
    logic [FETCH_W-1:0] target;
  } op_req_t;

  typedef struct packed {
    logic valid;
    logic we;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_t;

  typedef struct packed {
    logic we;
    logic re;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage : cpu_core_pkg

// ---- mul_unit.sv ----
`timescale 1ns/1ps
module mul_unit
  import cpu_core_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic start,
  input wire mul_kind_t kind,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic done,
  output logic [15:0] product,
  output logic carry
);
  logic signed [8:0] sa;
  logic signed [8:0] sb;
  logic signed [17:0] full;

  // sign extension by variant; mixed form treats b as unsigned
  always_comb begin
    sa = (kind[1:0] != 2'b00) ? {a[7], a} : {1'b0, a}; // [RQ4]
    sb = (kind[1:0] == 2'b01) ? {b[7], b} : {1'b0, b};
    full = sa * sb;
  end

  // one register stage: issue cycle plus result cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done <= 1'b0;
      product <= 16'h0000;
      carry <= 1'b0;
    end else begin
      done <= start; // [RQ5]
      if (start) begin
        carry <= full[15];
        // fractional result is shifted left, carry from before shift
        product <= kind[2] ? {full[14:0], 1'b0} : full[15:0]; // [RQ4]
      end
    end
  end
endmodule : mul_unit

// ---- cpu_alu_regfile_stack_core.sv ----
`timescale 1ns/1ps
module cpu_alu_regfile_stack_core
  import cpu_core_pkg::*;
#(
  parameter logic [15:0] SRAM_TOP = SRAM_TOP_RST,
  parameter int PROG_KB = PROG_KB_RST
)(
  input wire logic clk_sys,
  input wire logic srst,
  input wire op_req_t op,
  input wire io_req_t io,
  input wire logic [7:0] mem_rdata,
  input wire logic [1:0] ptr_sel,
  output logic busy,
  output mem_req_t mem,
  output logic [7:0] io_rdata,
  output logic [FETCH_W-1:0] fetch_address_counter,
  output logic [15:0] stack_top_pointer,
  output logic [7:0] flag_register,
  output logic irq_block,
  output logic [15:0] ptr_value
);
  localparam int RET_BYTES = (PROG_KB > RET_SPLIT_KB) ? 3 : 2;
  localparam logic [1:0] RET_LAST = 2'(RET_BYTES - 1);
  localparam int RET_GAP = RET_BYTES - 1;

  if (SRAM_TOP < SRAM_BASE || PROG_KB < 1) begin : g_bad_param
    $error("stack top below sram base or bad program size");
  end

  logic [7:0] rf [RF_DEPTH];
  state_t state;
  state_t next_state;
  op_req_t held;
  logic take;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] x;
  logic [7:0] y;
  logic [7:0] res;
  logic [8:0] sum;
  logic cin;
  logic [15:0] pair;
  logic [15:0] res16;
  logic [7:0] next_flags;
  logic [FETCH_W-1:0] next_fetch;
  logic [23:0] ret_addr;
  logic [1:0] byte_cnt;
  logic [2:0] guard;
  logic [2:0] next_guard;
  logic mul_done;
  logic mul_c;
  logic [15:0] mul_p;
  logic stack_lo_wr;

  function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
    if (sel == 2'b00) return PTR_A_LO;
    else if (sel == 2'b01) return PTR_B_LO;
    else return PTR_C_LO;
  endfunction : ptr_lo

  // operand fetch straight from the array, single-cycle access
  assign take = op.valid && (state == ST_IDLE);
  assign a = rf[op.dst];
  assign b = op.use_imm ? op.imm : rf[op.src]; // [RQ1]
  assign pair = {rf[op.dst | 5'h01], rf[op.dst & 5'h1E]}; // [RQ17]
  assign next_fetch = fetch_address_counter +
                      FETCH_W'(op.two_word ? 2 : 1); // [RQ7]
  assign stack_lo_wr = io.valid && io.we && (io.addr == IO_STACK_LO);

  mul_unit u_mul (
    .clk_sys(clk_sys),
    .srst(srst),
    .start(take && op.kind == OP_MUL),
    .kind(op.mk),
    .a(a),
    .b(rf[op.src]),
    .done(mul_done),
    .product(mul_p),
    .carry(mul_c)
  );

  // result and flag computation for 8-bit and word operations
  always_comb begin
    cin = (op.fn == FN_ADC || op.fn == FN_SBC) ?
          flag_register[FLAG_C] : 1'b0;
    next_flags = flag_register;
    res = a;
    res16 = pair;
    x = (op.fn == FN_NEG) ? 8'h00 : a;
    y = (op.fn == FN_NEG) ? a : b;
    sum = 9'h000;
    if (op.kind == OP_ALU16) begin
      // word add/subtract of a 6-bit immediate on a pair [RQ3]
      res16 = (op.fn == FN_SUB) ? pair - {10'h000, op.imm[5:0]} :
                                  pair + {10'h000, op.imm[5:0]};
      next_flags[FLAG_C] = (op.fn == FN_SUB) ? res16[15] & ~pair[15] :
                                               ~res16[15] & pair[15];
      next_flags[FLAG_V] = (op.fn == FN_SUB) ? pair[15] & ~res16[15] :
                                               ~pair[15] & res16[15];
      next_flags[FLAG_N] = res16[15];
      next_flags[FLAG_Z] = (res16 == 16'h0000);
      next_flags[FLAG_S] = next_flags[FLAG_N] ^ next_flags[FLAG_V];
    end else begin
      case (op.fn)
        FN_ADD, FN_ADC: begin
          sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
          res = sum[7:0];
          next_flags[FLAG_C] = sum[8];
          next_flags[FLAG_H] = a[3] & b[3] | b[3] & ~res[3] |
                               ~res[3] & a[3];
          next_flags[FLAG_V] = a[7] & b[7] & ~res[7] |
                               ~a[7] & ~b[7] & res[7];
        end
        FN_SUB, FN_SBC, FN_NEG: begin
          sum = {1'b0, x} - {1'b0, y} - {8'h00, cin};
          res = sum[7:0];
          next_flags[FLAG_C] = sum[8];
          next_flags[FLAG_H] = ~x[3] & y[3] | y[3] & res[3] |
                               res[3] & ~x[3];
          next_flags[FLAG_V] = x[7] & ~y[7] & ~res[7] |
                               ~x[7] & y[7] & res[7];
        end
        FN_AND: res = a & b;
        FN_OR: res = a | b;
        FN_XOR: res = a ^ b;
        FN_COM: begin
          res = ~a;
          next_flags[FLAG_C] = 1'b1;
        end
        FN_INC: begin
          res = a + 8'h01;
          next_flags[FLAG_V] = (res == 8'h80);
        end
        FN_DEC: begin
          res = a - 8'h01;
          next_flags[FLAG_V] = (res == 8'h7F);
        end
        FN_LSR: begin
          res = {1'b0, a[7:1]};
          next_flags[FLAG_C] = a[0];
        end
        FN_ROR: begin
          res = {flag_register[FLAG_C], a[7:1]};
          next_flags[FLAG_C] = a[0];
        end
        FN_ASR: begin
          res = {a[7], a[7:1]};
          next_flags[FLAG_C] = a[0];
        end
        FN_SWAP: res = {a[3:0], a[7:4]};
        default: res = b;
      endcase
      // swap and move leave the flags alone, all others refresh [RQ2]
      if (op.fn != FN_SWAP && op.fn != FN_MOV) begin
        next_flags[FLAG_N] = res[7];
        // chained subtract keeps zero only if the lower byte was zero
        next_flags[FLAG_Z] = (op.fn == FN_SBC) ?
          (res == 8'h00) & flag_register[FLAG_Z] : (res == 8'h00);
        if (op.fn == FN_AND || op.fn == FN_OR || op.fn == FN_XOR ||
            op.fn == FN_COM) begin
          next_flags[FLAG_V] = 1'b0;
        end else if (op.fn == FN_LSR || op.fn == FN_ROR ||
                     op.fn == FN_ASR) begin
          next_flags[FLAG_V] = res[7] ^ a[0];
        end
        next_flags[FLAG_S] = next_flags[FLAG_N] ^ next_flags[FLAG_V];
      end
    end
  end

  // sequencing of multiply, return push and stack pops
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          case (op.kind)
            OP_MUL: next_state = ST_MUL;
            OP_CALL, OP_INTR: next_state = ST_CALL;
            OP_POP, OP_RETURN_FROM_CALL,
            OP_RETURN_FROM_INTERRUPT: next_state = ST_POP;
            default: next_state = ST_IDLE;
          endcase
        end
      end
      ST_MUL: if (mul_done) next_state = ST_IDLE;
      ST_CALL: if (byte_cnt == RET_LAST) next_state = ST_IDLE;
      ST_POP: next_state = ST_WAIT;
      ST_WAIT: next_state = ST_CAP;
      ST_CAP: begin
        next_state = (held.kind != OP_POP && byte_cnt != RET_LAST) ?
                     ST_POP : ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= ST_IDLE;
      busy <= 1'b0;
      held <= '0;
    end else begin
      state <= next_state;
      busy <= (next_state != ST_IDLE);
      if (take) held <= op;
    end
  end

  // return address bytes: counted out on push, shifted in on pop
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      byte_cnt <= 2'b00;
      ret_addr <= 24'h000000;
    end else if (take) begin
      byte_cnt <= 2'b00;
      // interrupt entry resumes at the current address
      ret_addr <= (op.kind == OP_INTR) ? 24'(fetch_address_counter) :
                  (op.kind == OP_CALL) ? 24'(next_fetch) : 24'h000000;
    end else if (state == ST_CALL || state == ST_CAP) begin
      byte_cnt <= byte_cnt + 2'b01;
      if (state == ST_CAP) ret_addr <= {ret_addr[15:0], mem_rdata};
    end
  end

  // register file writes; one writer per cycle by construction
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      for (int i = 0; i < RF_DEPTH; i++) rf[i] <= 8'h00;
    end else if (take && op.kind == OP_ALU && op.wb) begin
      rf[op.dst] <= res; // [RQ1]
    end else if (take && op.kind == OP_ALU16 && op.wb) begin
      rf[op.dst & 5'h1E] <= res16[7:0]; // [RQ17]
      rf[op.dst | 5'h01] <= res16[15:8];
    end else if (state == ST_MUL && mul_done) begin
      rf[MUL_LO] <= mul_p[7:0]; // [RQ5]
      rf[MUL_HI] <= mul_p[15:8];
    end else if (state == ST_CAP && held.kind == OP_POP) begin
      rf[held.dst] <= mem_rdata; // [RQ10]
    end
  end

  // flags: software write first so a hardware update wins the cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flag_register <= FLAGS_RST;
    end else begin
      if (io.valid && io.we && io.addr == IO_FLAGS) begin
        flag_register <= io.wdata;
      end
      // call, interrupt entry and returns never touch flags [RQ16]
      if (take && (op.kind == OP_ALU || op.kind == OP_ALU16)) begin
        flag_register <= next_flags; // [RQ2]
      end else if (state == ST_MUL && mul_done) begin
        flag_register[FLAG_C] <= mul_c;
        flag_register[FLAG_Z] <= (mul_p == 16'h0000);
      end
    end
  end

  // stack pointer: I/O bytes first, stack motion overrides
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stack_top_pointer <= SRAM_TOP; // [RQ8] [RQ19]
    end else begin
      if (stack_lo_wr) stack_top_pointer[7:0] <= io.wdata; // [RQ9]
      if (io.valid && io.we && io.addr == IO_STACK_HI) begin
        stack_top_pointer[15:8] <= io.wdata; // [RQ9]
      end
      if ((take && op.kind == OP_PUSH) || state == ST_CALL) begin
        stack_top_pointer <= stack_top_pointer - 16'h0001; // [RQ10]
      end else if (state == ST_POP) begin
        stack_top_pointer <= stack_top_pointer + 16'h0001; // [RQ10]
      end
    end
  end

  // data memory strobes; pop reads the byte above the pointer
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mem <= '0;
    end else begin
      mem.we <= 1'b0;
      mem.re <= 1'b0;
      if (take && op.kind == OP_PUSH) begin
        mem.we <= 1'b1; // [RQ10]
        mem.addr <= stack_top_pointer;
        mem.wdata <= rf[op.src];
      end else if (state == ST_CALL) begin
        mem.we <= 1'b1; // [RQ11] [RQ12]
        mem.addr <= stack_top_pointer;
        mem.wdata <= ret_addr[{byte_cnt, 3'b000} +: 8];
      end else if (state == ST_POP) begin
        mem.re <= 1'b1; // [RQ13]
        mem.addr <= stack_top_pointer + 16'h0001;
      end
    end
  end

  // fetch address counter
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      fetch_address_counter <= FETCH_RST; // [RQ6]
    end else if (take && op.kind == OP_CALL) begin
      fetch_address_counter <= op.target;
    end else if (take && op.kind == OP_INTR) begin
      fetch_address_counter <= op.target;
    end else if (take && op.kind != OP_RETURN_FROM_CALL &&
                 op.kind != OP_RETURN_FROM_INTERRUPT) begin
      fetch_address_counter <= next_fetch; // [RQ7]
    end else if (state == ST_CAP && held.kind != OP_POP &&
                 byte_cnt == RET_LAST) begin
      fetch_address_counter <= FETCH_W'({ret_addr[15:0], mem_rdata}); // [RQ13]
    end
  end

  // interrupt guard after a low-byte pointer write
  always_comb begin
    next_guard = guard;
    if (stack_lo_wr) begin
      next_guard = GUARD_INSTR; // [RQ14]
    end else if (io.valid && io.we) begin
      next_guard = 3'h0; // [RQ14]
    end else if (take && guard != 3'h0) begin
      next_guard = guard - 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      guard <= 3'h0;
      irq_block <= 1'b0;
    end else begin
      guard <= next_guard;
      irq_block <= (next_guard != 3'h0);
    end
  end

  // I/O readback and pointer pair readback
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      io_rdata <= 8'h00;
      ptr_value <= 16'h0000;
    end else begin
      ptr_value <= {rf[ptr_lo(ptr_sel) | 5'h01], rf[ptr_lo(ptr_sel)]}; // [RQ18]
      if (io.valid && !io.we && io.addr == IO_STACK_LO) begin
        io_rdata <= stack_top_pointer[7:0]; // [RQ9]
      end else if (io.valid && !io.we && io.addr == IO_STACK_HI) begin
        io_rdata <= stack_top_pointer[15:8];
      end else if (io.valid && !io.we && io.addr == IO_FLAGS) begin
        io_rdata <= flag_register;
      end else if (io.valid && !io.we) begin
        io_rdata <= 8'h00;
      end
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_FETCH_RESET: assert property ($fell(srst) |->
    fetch_address_counter == FETCH_RST) // [RQ6]
    else $error("fetch counter not zero after reset");
  AST_STACK_RESET: assert property ($fell(srst) |->
    stack_top_pointer == SRAM_TOP) // [RQ8]
    else $error("stack pointer not at sram top after reset");
  AST_ADD_ONE: assert property (take && op.kind == OP_ALU && op.wb &&
    op.fn == FN_ADD |=> rf[$past(op.dst)] == $past(a) + $past(b)) // [RQ1]
    else $error("add result not written in one cycle");
  AST_ZERO_FLAG: assert property (take && op.kind == OP_ALU && op.wb &&
    op.fn != FN_SWAP && op.fn != FN_MOV && op.fn != FN_SBC |=>
    flag_register[FLAG_Z] == (rf[$past(op.dst)] == 8'h00)) // [RQ2]
    else $error("zero flag does not match result");
  AST_MUL_TWO: assert property (take && op.kind == OP_MUL |=>
    busy ##1 !busy && {rf[MUL_HI], rf[MUL_LO]} == $past(mul_p)) // [RQ5]
    else $error("multiply not done in two cycles");
  AST_PUSH_DEC: assert property (take && op.kind == OP_PUSH && !io.valid
    |=> mem.we && stack_top_pointer == $past(stack_top_pointer) - 16'h0001
    && mem.addr == $past(stack_top_pointer)) // [RQ10]
    else $error("push did not store and decrement");
  AST_POP_INC: assert property (state == ST_POP && !io.valid |=>
    mem.re && stack_top_pointer == $past(stack_top_pointer) + 16'h0001)
    else $error("pop did not increment"); // [RQ10]
  AST_CALL_FLAGS: assert property (take && (op.kind == OP_CALL ||
    op.kind == OP_INTR) && !io.valid |=> $stable(flag_register)[*2])
    else $error("flags changed on call entry"); // [RQ16]
  AST_CALL_LEN: assert property (take && op.kind == OP_CALL |=>
    busy[*2] ##RET_GAP !busy) // [RQ12]
    else $error("return push length wrong");
  AST_GUARD_SET: assert property (stack_lo_wr |=> irq_block) // [RQ14]
    else $error("low pointer write did not block interrupts");
  AST_GUARD_END: assert property (stack_lo_wr ##1 (take && !io.valid)[*4]
    |=> !irq_block) // [RQ14]
    else $error("interrupt block held past four instructions");

  COV_MUL: cover property (take && op.kind == OP_MUL ##2 !busy);
  COV_CALL: cover property (take && op.kind == OP_CALL);
  COV_RET: cover property (state == ST_CAP && held.kind ==
    OP_RETURN_FROM_CALL && byte_cnt == RET_LAST);
  COV_GUARD: cover property (stack_lo_wr ##1 irq_block);
endmodule : cpu_alu_regfile_stack_core

// ---- data_mem_model.sv ----
`timescale 1ns/1ps
module data_mem_model
  import cpu_core_pkg::*;
(
  input wire logic clk_sys,
  input wire mem_req_t mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] cells [0:65535];
  logic hit = 1'b0;
  logic [7:0] last = 8'h00;
  // write takes one cycle; read data shows the cycle after the strobe
  always @(posedge clk_sys) begin
    if (mem.we) cells[mem.addr] <= mem.wdata;
    hit <= mem.re;
    if (mem.re) last <= cells[mem.addr];
  end
  // idle bus shows the inverse, so a late capture cannot pass by luck
  assign mem_rdata = hit ? last : ~last;
endmodule : data_mem_model

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import cpu_core_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  op_req_t op = '0;
  io_req_t io = '0;
  logic [1:0] ptr_sel = 2'h0;
  logic busy, irq_block;
  mem_req_t mem;
  logic [7:0] io_rdata, flag_register, mem_rdata;
  logic [FETCH_W-1:0] fetch_address_counter;
  logic [15:0] stack_top_pointer, ptr_value;
  int failures = 0;
  int checks = 0;
  mul_kind_t mks [6] = '{MK_UU, MK_SS, MK_SU, MK_FUU, MK_FSS, MK_FSU};
  logic [15:0] mexp [6] = '{16'h01FE, 16'hFFFE, 16'hFFFE, 16'h03FC,
    16'hFFFC, 16'hFFFC};

  always #20 clk_sys = ~clk_sys;

  cpu_alu_regfile_stack_core i_dut (.clk_sys(clk_sys), .srst(srst),
    .op(op), .io(io), .mem_rdata(mem_rdata), .ptr_sel(ptr_sel),
    .busy(busy), .mem(mem), .io_rdata(io_rdata),
    .fetch_address_counter(fetch_address_counter),
    .stack_top_pointer(stack_top_pointer), .flag_register(flag_register),
    .irq_block(irq_block), .ptr_value(ptr_value));
  data_mem_model i_mem (.clk_sys(clk_sys), .mem(mem),
    .mem_rdata(mem_rdata));

  task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // bounded wait for the end of a multi-cycle sequence
  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0) begin
      n++;
      if (n > 20) begin
        failures++;
        results();
      end
      @(negedge clk_sys);
    end
  endtask : idle

  function automatic op_req_t mk(input op_kind_t k, input alu_fn_t f,
      input logic [4:0] d, input logic [4:0] s, input logic [7:0] v);
    mk = '0;
    mk.kind = k;
    mk.fn = f;
    mk.dst = d;
    mk.src = s;
    mk.imm = v;
    mk.use_imm = 1'b1;
    mk.wb = 1'b1;
  endfunction : mk

  // called at a falling edge; returns at the one after the taking edge
  task automatic issue(input op_req_t r);
    op = r;
    op.valid = 1'b1;
    @(negedge clk_sys);
    op.valid = 1'b0;
  endtask : issue

  task automatic alu(input alu_fn_t f, input logic [4:0] d,
      input logic [7:0] v);
    issue(mk(OP_ALU, f, d, 5'h00, v));
    @(negedge clk_sys);
  endtask : alu

  task automatic io_op(input logic w, input logic [5:0] a,
      input logic [7:0] d);
    io.valid = 1'b1;
    io.we = w;
    io.addr = a;
    io.wdata = d;
    @(negedge clk_sys);
    io.valid = 1'b0;
    io.we = 1'b0;
    // one idle cycle so back-to-back calls never re-raise valid at once
    @(negedge clk_sys);
  endtask : io_op

  task automatic push(input logic [4:0] s, output logic [7:0] d);
    logic [15:0] sp;
    sp = stack_top_pointer;
    issue(mk(OP_PUSH, FN_MOV, 5'h00, s, 8'h00));
    chk("push strobe", mem.we, 1'b1);
    chk("push addr", mem.addr, sp);
    chk("sp after push", stack_top_pointer, sp - 16'h1);
    d = mem.wdata;
    @(negedge clk_sys);
  endtask : push

  initial begin
    op_req_t r;
    logic [7:0] hi, lo;
    logic [7:0] f0;
    repeat (6) @(negedge clk_sys);
    srst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("fetch at reset", fetch_address_counter, 0);
    chk("sp at reset", stack_top_pointer, 16'h3FFF);
    chk("flags at reset", flag_register, FLAGS_RST);
    $display("test reset done");
    // immediate arithmetic, compare without write-back, pointer pair
    alu(FN_MOV, 5'h1A, 8'h0F);
    alu(FN_MOV, 5'h1B, 8'h80);
    alu(FN_ADD, 5'h1A, 8'h01);
    chk("half carry", flag_register, 8'h20);
    r = mk(OP_ALU, FN_SUB, 5'h1A, 5'h00, 8'h10);
    r.wb = 1'b0;
    issue(r);
    @(negedge clk_sys);
    chk("zero flag", flag_register, 8'h02);
    chk("pointer pair", ptr_value, 16'h8010);
    issue(mk(OP_ALU16, FN_ADD, 5'h1A, 5'h00, 8'h01));
    @(negedge clk_sys);
    chk("wide add", ptr_value, 16'h8011);
    $display("test alu done");
    // every multiply kind, product read back through pushes
    alu(FN_MOV, 5'h10, 8'hFF);
    alu(FN_MOV, 5'h11, 8'h02);
    for (int k = 0; k < 6; k++) begin
      r = mk(OP_MUL, FN_MOV, 5'h10, 5'h11, 8'h00);
      r.mk = mks[k];
      issue(r);
      chk("busy first cycle", busy, 1'b1);
      @(negedge clk_sys);
      chk("busy second cycle", busy, 1'b0);
      push(MUL_HI, hi);
      push(MUL_LO, lo);
      chk("product", {hi, lo}, mexp[k]);
    end
    $display("test multiply done");
    // push then pop round trip into the pointer pair
    alu(FN_MOV, 5'h14, 8'hA5);
    push(5'h14, lo);
    f0 = stack_top_pointer;
    issue(mk(OP_POP, FN_MOV, 5'h1A, 5'h00, 8'h00));
    idle();
    @(negedge clk_sys);
    chk("popped byte", ptr_value[7:0], 8'hA5);
    chk("sp after pop", stack_top_pointer[7:0], f0 + 8'h1);
    $display("test stack done");
    // guard window after a low pointer byte write
    io_op(1'b1, IO_STACK_LO, 8'hFD);
    @(negedge clk_sys);
    chk("guard set", irq_block, 1'b1);
    repeat (3) alu(FN_MOV, 5'h14, 8'h00);
    chk("guard after three", irq_block, 1'b1);
    alu(FN_MOV, 5'h14, 8'h00);
    chk("guard after four", irq_block, 1'b0);
    io_op(1'b1, IO_STACK_LO, 8'hFD);
    io_op(1'b1, IO_STACK_HI, 8'h2F); // pointer kept above base
    @(negedge clk_sys);
    chk("guard cut by write", irq_block, 1'b0);
    io_op(1'b0, IO_STACK_LO, 8'h00);
    chk("sp low read", io_rdata, 8'hFD);
    io_op(1'b0, IO_STACK_HI, 8'h00);
    chk("sp high read", io_rdata, 8'h2F);
    io_op(1'b0, 6'h10, 8'h00);
    chk("unmapped read", io_rdata, 8'h00);
    io_op(1'b1, IO_FLAGS, 8'hC1);
    chk("flags write", flag_register, 8'hC1);
    $display("test io done");
    // call, then both returns from a prepared stack
    issue(mk(OP_CALL, FN_MOV, 5'h00, 5'h00, 8'h00));
    chk("call target", fetch_address_counter, 0);
    idle();
    chk("sp after call", stack_top_pointer, 16'h2FFB);
    for (int k = 0; k < 2; k++) begin
      io_op(1'b1, IO_STACK_LO, 8'hFD);
      io_op(1'b1, IO_STACK_HI, 8'h2F);
      i_mem.cells[16'h2FFE] = 8'h12 + k[7:0];
      i_mem.cells[16'h2FFF] = 8'h34;
      issue(mk(k ? OP_RETURN_FROM_INTERRUPT : OP_RETURN_FROM_CALL,
        FN_MOV, 5'h00, 5'h00, 8'h00));
      idle();
      chk("return addr", fetch_address_counter, {8'h12 + k[7:0], 8'h34});
      chk("sp after return", stack_top_pointer, 16'h2FFF);
      chk("flags kept", flag_register, 8'hC1);
    end
    $display("test call done");
    results();
  end
endmodule : testbench
